// File: logic/tbc_capture.v
// two-channel capture of the 32 hz to 256 hz time base taps on a pin trigger
// assumes taps and the 2 khz tick come from a time base counter on clk_sys,
// and trigger pins are asynchronous and pass a two-stage synchroniser
//
// Overview of operation
// - channel 0 flag sets on 2 khz rise if enabled and pin 0 active
// - flag 0 set closes latch 0, holding the current four tap bits
// - reading capture value zero clears flag 0
// - writing one to flag 0 captures at once, regardless of pin 0 level and of the 2 khz rise
// - clearing enable 0 while held cancels the latch
// - flag 0 or enable 0 low: capture value zero reads live taps
// - channel 1 flag sets on 2 khz rise if enabled and pin 1 active
// - flag 1 set closes latch 1, holding the current four tap bits
// - reading capture value one clears flag 1
// - writing one to flag 1 captures regardless of pin 1 level
// - flag 1 or enable 1 low: capture value one reads live taps
// - control bit 3 is flag 1, bit 2 is flag 0
// - control bit 1 enables channel 1, bit 0 channel 0; disabled never latches
// - capture bits: 3 is 32 hz, 2 is 64 hz, 1 is 128 hz, 0 is 256 hz
// - reset clears flags, enables and capture registers
`include "tbc_regs.vh"

module tbc_capture (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // register port
    input wire [7:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [3:0] reg_rdata,
    // time base
    input wire [3:0] tb_taps,
    input wire tb_tick_2khz,
    // trigger pins
    input wire trigger_pin_zero,
    input wire trigger_pin_one,
    // status
    output wire [1:0] capture_latched,
    output wire irq
);

    localparam NCH = 2;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    function [7:0] value_offset;
        input integer ch;
        begin
            if (ch == 0) begin
                value_offset = `TBC_OFF_CAPTURE_VALUE_ZERO;
            end else begin
                value_offset = `TBC_OFF_CAPTURE_VALUE_ONE;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    wire [1:0] pin_sync;
    reg tick_prev;
    wire tick_rise;
    reg [1:0] enable;
    reg [1:0] flag;
    reg [1:0] pull_down;
    reg [1:0] int_status;
    reg [1:0] int_mask;
    wire [1:0] flag_set;
    wire [1:0] flag_event;
    wire [1:0] flag_clear;
    wire [1:0] latched;
    wire [3:0] view0;
    wire [3:0] view1;
    wire wr_control;
    wire wr_pull;
    wire wr_mask;
    wire rd_status;
    reg [3:0] next_rdata;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    tbc_sync #(
        .WIDTH(NCH)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in({trigger_pin_one, trigger_pin_zero}),
        .sync_out(pin_sync)
    );

    // ----------------------------------------------------------------
    // 2 khz tick edge
    // ----------------------------------------------------------------
    // tick is already on clk_sys, so no synchroniser
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= tb_tick_2khz;
        end
    end

    assign tick_rise = tb_tick_2khz & ~tick_prev;

    // ----------------------------------------------------------------
    // register strobes
    // ----------------------------------------------------------------
    assign wr_control = reg_wr & hit(reg_addr, `TBC_OFF_CAPTURE_CONTROL);
    assign wr_pull = reg_wr & hit(reg_addr, `TBC_OFF_TRIGGER_PULL);
    assign wr_mask = reg_wr & hit(reg_addr, `TBC_OFF_INT_MASK);
    assign rd_status = reg_rd & hit(reg_addr, `TBC_OFF_INT_STATUS);

    // ----------------------------------------------------------------
    // enables and pull selection
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            enable <= `TBC_RST_CAPTURE_ENABLE;
        end else if (wr_control) begin
            enable <= reg_wdata[`TBC_CTL_ENABLE_LSB +: 2];
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pull_down <= `TBC_RST_TRIGGER_PULL;
        end else if (wr_pull) begin
            pull_down <= reg_wdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // per-channel flag and hold latch
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            wire pin_active;
            wire hw_set;
            wire sw_set;
            reg [3:0] hold;

            // active low with pull-up, active high with pull-down
            assign pin_active = ~(pin_sync[ch] ^ pull_down[ch]);
            assign hw_set = tick_rise & enable[ch] & pin_active;
            // writing zero to a flag bit leaves it alone
            assign sw_set = wr_control & reg_wdata[`TBC_CTL_FLAG_LSB + ch];
            assign flag_set[ch] = hw_set | sw_set;
            assign flag_clear[ch] = reg_rd & hit(reg_addr, value_offset(ch));
            assign flag_event[ch] = flag_set[ch] & ~flag[ch];

            // set wins over a read clear in the same cycle
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    flag[ch] <= 1'b0;
                end else if (flag_set[ch]) begin
                    flag[ch] <= 1'b1;
                end else if (flag_clear[ch]) begin
                    flag[ch] <= 1'b0;
                end
            end

            // latch closes while flag and enable are both high; dropping
            // either reopens it, so the held value tracks live taps again
            assign latched[ch] = flag[ch] & enable[ch];

            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    hold <= `TBC_RST_CAPTURE_VALUE;
                end else if (!latched[ch]) begin
                    hold <= tb_taps;
                end
            end
        end
    endgenerate

    assign capture_latched = latched;

    // ----------------------------------------------------------------
    // read views: held value or live taps
    // ----------------------------------------------------------------
    assign view0 = latched[0] ? g_ch[0].hold : tb_taps;
    assign view1 = latched[1] ? g_ch[1].hold : tb_taps;

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // a capture event arriving in the clearing read is kept
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            int_status <= `TBC_RST_INT_STATUS;
        end else if (rd_status) begin
            int_status <= flag_event;
        end else begin
            int_status <= int_status | flag_event;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            int_mask <= `TBC_RST_INT_MASK;
        end else if (wr_mask) begin
            int_mask <= reg_wdata[1:0];
        end
    end

    assign irq = |(int_status & int_mask);

    // ----------------------------------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 4'h0;
        case (reg_addr)
            `TBC_OFF_CAPTURE_VALUE_ZERO: begin
                next_rdata = view0;
            end
            `TBC_OFF_CAPTURE_VALUE_ONE: begin
                next_rdata = view1;
            end
            `TBC_OFF_CAPTURE_CONTROL: begin
                next_rdata = {flag[1], flag[0], enable[1], enable[0]};
            end
            `TBC_OFF_TRIGGER_PULL: begin
                next_rdata = {2'h0, pull_down};
            end
            `TBC_OFF_INT_STATUS: begin
                next_rdata = {2'h0, int_status};
            end
            `TBC_OFF_INT_MASK: begin
                next_rdata = {2'h0, int_mask};
            end
            default: begin
                next_rdata = 4'h0;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= `TBC_RST_READ_DATA;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 4'h0;
        end
    end

endmodule

// File: logic/tbc_regs.vh
// register offsets, field positions and reset values of the time base capture unit
// assumes an 8-bit register address and 4-bit register data
`ifndef TBC_REGS_VH
`define TBC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TBC_OFF_CAPTURE_VALUE_ZERO 8'h0c
`define TBC_OFF_CAPTURE_VALUE_ONE 8'h0d
`define TBC_OFF_CAPTURE_CONTROL 8'h0e
`define TBC_OFF_TRIGGER_PULL 8'h10
`define TBC_OFF_INT_STATUS 8'h11
`define TBC_OFF_INT_MASK 8'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TBC_CTL_ENABLE_LSB 0
`define TBC_CTL_FLAG_LSB 2
`define TBC_TAP_256HZ 0
`define TBC_TAP_128HZ 1
`define TBC_TAP_64HZ 2
`define TBC_TAP_32HZ 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TBC_RST_CAPTURE_VALUE 4'h0
`define TBC_RST_CAPTURE_CONTROL 4'h0
`define TBC_RST_CAPTURE_ENABLE 2'h0
`define TBC_RST_TRIGGER_PULL 2'h0
`define TBC_RST_INT_STATUS 2'h0
`define TBC_RST_INT_MASK 2'h0
`define TBC_RST_READ_DATA 4'h0

`endif

// File: logic/tbc_sync.v
// two flip-flop synchroniser for a group of asynchronous levels
// assumes the inputs come from pins outside the clk_sys domain
module tbc_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    // ----------------------------------------------------------------
    // two stages; the first stage feeds only the second
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] meta;

    always @(posedge clk_sys or negedge rstn) begin
        // pins rest high under the pull-up chosen at reset; starting low
        // would show a false active level for two cycles after release
        if (!rstn) begin
            meta <= {WIDTH{1'h1}};
            sync_out <= {WIDTH{1'h1}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// File: sim/tbc_capture_sva.sv
// port checker for the time base capture unit
// assumes one clock domain and read data one cycle after the strobe
module tbc_capture_sva (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // register port
    input wire [7:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_rdata,
    // time base and pins
    input wire [3:0] tb_taps,
    input wire tb_tick_2khz,
    input wire trigger_pin_zero,
    input wire trigger_pin_one,
    // status
    input wire [1:0] capture_latched,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    logic tick_d;
    wire tick_rise = tb_tick_2khz && !tick_d;
    wire ctl_wr = reg_wr && reg_addr == 8'h0e;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            tick_d <= 1'b0;
        else
            tick_d <= tb_tick_2khz;
    end
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 4'h0)
        else $error("read data outside answer cycle");
    a_sw_latch_zero: assert property (ctl_wr && reg_wdata[2] && reg_wdata[0] |=> capture_latched[0])
        else $error("software capture zero missed");
    a_sw_latch_one: assert property (ctl_wr && reg_wdata[3] && reg_wdata[1] |=> capture_latched[1])
        else $error("software capture one missed");
    a_disable_cancels: assert property (ctl_wr && !reg_wdata[0] |=> !capture_latched[0])
        else $error("latch zero not cancelled");
    a_read_clears: assert property (reg_rd && reg_addr == 8'h0d && !tick_rise |=> !capture_latched[1])
        else $error("flag one not cleared by read");
    a_live_read: assert property (reg_rd && reg_addr == 8'h0c && !capture_latched[0] |=> reg_rdata == $past(tb_taps))
        else $error("open latch zero not live");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12}) |=> reg_rdata == 4'h0)
        else $error("unmapped read not zero");
    a_latch_cause: assert property ($rose(capture_latched[0]) |-> $past(ctl_wr) || $past(tick_rise))
        else $error("latch zero closed without cause");
endmodule

bind tbc_capture tbc_capture_sva i_sva (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tb_taps(tb_taps), .tb_tick_2khz(tb_tick_2khz), .trigger_pin_zero(trigger_pin_zero),
    .trigger_pin_one(trigger_pin_one), .capture_latched(capture_latched), .irq(irq));

// File: sim/tbc_trigger_model.sv
// two trigger switches with pull resistors
// assumes the pull choice mirrors the unit's pull register
module tbc_trigger_model (
    // clock
    input wire clk_sys,
    // press and pull choice
    input wire [1:0] press,
    input wire [1:0] pull_down,
    // pins
    output logic trigger_pin_zero = 1'b1,
    output logic trigger_pin_one = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins move off the sampling edge, as a switch would; released pins rest at the pull level
    always @(negedge clk_sys) begin
        trigger_pin_zero <= press[0] ? pull_down[0] : ~pull_down[0];
        trigger_pin_one <= press[1] ? pull_down[1] : ~pull_down[1];
    end
endmodule

// File: sim/test_two_channel_timebase_capture.sv
// self-checking bench for the time base capture unit
// assumes the bench model mirrors register state at each rising edge
module test_two_channel_timebase_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] tb_taps = 4'h0;
    logic tb_tick_2khz = 1'b0;
    logic [1:0] press = 2'h0;
    logic rnd_pins = 1'b0;
    logic [7:0] tb_count = 8'h00;
    wire [3:0] reg_rdata;
    wire trigger_pin_zero;
    wire trigger_pin_one;
    wire [1:0] capture_latched;
    wire irq;
    integer seed = 28;
    integer bad_count = 0;
    integer checks = 0;
    integer i;
    integer c;
    logic [1:0] m_flag, m_en, m_pull, m_stat, m_mask, m_set, m_lat, s1, s2;
    logic [3:0] m_hold [0:1];
    logic [3:0] exp_rd;
    logic m_irq, tick_d;
    logic [7:0] addr_tab [0:7] = '{8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h0f, 8'h3a};
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    tbc_trigger_model i_pins (.clk_sys(clk_sys), .press(press), .pull_down(m_pull),
        .trigger_pin_zero(trigger_pin_zero), .trigger_pin_one(trigger_pin_one));
    tbc_capture i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tb_taps(tb_taps), .tb_tick_2khz(tb_tick_2khz), .trigger_pin_zero(trigger_pin_zero),
        .trigger_pin_one(trigger_pin_one), .capture_latched(capture_latched), .irq(irq));
    // short time base: tick period of 8 cycles keeps the run small
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tb_count <= 8'h00;
            tb_taps <= 4'h0;
            tb_tick_2khz <= 1'b0;
        end else begin
            tb_count <= tb_count + 8'h01;
            tb_taps <= tb_count[7:4];
            tb_tick_2khz <= tb_count[2];
        end
    end
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {m_flag, m_en, m_pull, m_stat, m_mask, s1, s2} = 14'h000f;
            m_hold[0] = 4'h0;
            m_hold[1] = 4'h0;
            {exp_rd, m_irq, tick_d} = 6'h0;
        end else begin
            m_lat = m_flag & m_en;
            exp_rd = 4'h0;
            if (reg_rd) begin
                case (reg_addr)
                    8'h0c: exp_rd = m_lat[0] ? m_hold[0] : tb_taps;
                    8'h0d: exp_rd = m_lat[1] ? m_hold[1] : tb_taps;
                    8'h0e: exp_rd = {m_flag, m_en};
                    8'h10: exp_rd = {2'h0, m_pull};
                    8'h11: exp_rd = {2'h0, m_stat};
                    8'h12: exp_rd = {2'h0, m_mask};
                    default: exp_rd = 4'h0;
                endcase
            end
            m_set = (reg_wr && reg_addr == 8'h0e) ? reg_wdata[3:2] : 2'h0;
            for (c = 0; c < 2; c = c + 1) begin
                if (tb_tick_2khz && !tick_d && m_en[c] && s2[c] == m_pull[c])
                    m_set[c] = 1'b1;
                if (!m_lat[c])
                    m_hold[c] = tb_taps;
            end
            if (reg_rd && reg_addr == 8'h11)
                m_stat = 2'h0;
            // an event is a set while the flag was low before this edge's read clear
            m_stat = m_stat | (m_set & ~m_flag);
            for (c = 0; c < 2; c = c + 1) begin
                if (reg_rd && reg_addr == 8'h0c + c)
                    m_flag[c] = 1'b0;
            end
            m_flag = m_flag | m_set;
            if (reg_wr && reg_addr == 8'h0e)
                m_en = reg_wdata[1:0];
            if (reg_wr && reg_addr == 8'h10)
                m_pull = reg_wdata[1:0];
            if (reg_wr && reg_addr == 8'h12)
                m_mask = reg_wdata[1:0];
            m_irq = |(m_stat & m_mask);
            s2 = s1;
            s1 = {trigger_pin_one, trigger_pin_zero};
            tick_d = tb_tick_2khz;
        end
    end
    always @(negedge clk_sys) begin
        if (rstn === 1'b1) begin
            check({2'h0, capture_latched}, {2'h0, m_flag & m_en});
            check(reg_rdata, exp_rd);
            check({3'h0, irq}, {3'h0, m_irq});
        end
    end
    task check(input logic [3:0] seen, input logic [3:0] expected);
        checks = checks + 1;
        if (seen !== expected) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task step(input logic wr, input logic rd, input logic [7:0] a, input logic [3:0] d);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk_sys);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        press <= rnd_pins ? r[1:0] : 2'h0;
    endtask
    task run_random(input integer n);
        logic [31:0] r;
        for (i = 0; i < n; i = i + 1) begin
            r = $random(seed);
            step(r[1:0] == 2'h1, r[1:0] == 2'h2, addr_tab[r[4:2]], r[8:5]);
        end
    endtask
    task do_reset(input integer n);
        step(1'b0, 1'b0, 8'h00, 4'h0);
        rstn <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    task close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        do_reset(12);
        for (i = 0; i < 8; i = i + 1)
            step(1'b0, 1'b1, addr_tab[i], 4'h0);
        // software capture with both pins released
        step(1'b1, 1'b0, 8'h0e, 4'hf);
        repeat (40) step(1'b0, 1'b0, 8'h00, 4'h0);
        step(1'b0, 1'b1, 8'h0c, 4'h0);
        step(1'b0, 1'b1, 8'h0d, 4'h0);
        rnd_pins <= 1'b1;
        run_random(3000);
        do_reset(3);
        run_random(1000);
        close_out;
    end
endmodule
